// ===== rtl/node_id_pin_mapper.sv
// Startup loader that forms the node identifier from input pins.
// Assumes pins are asynchronous straps and software writes the
// configuration before starting the one-time capture.
`timescale 1ns/10ps

// Behaviour
// - Pin count register selects how many pins; zero count means no pin mapping.
// - Lowest nibble of mapping register names the pin for identifier bit 0.
// - Nibbles 1 to 6 name pins for identifier bits 1 to 6; 28-30 reserved.
// - Mapping bit 31 enables custom nibble mapping, else default mapping applies.
// - With bit 31 clear, all other mapping fields are ignored.
// - Default uses the highest pins ascending; higher pin feeds higher bit.
// - Each nibble is a pin index from 0 to 15.
// - Identifier is captured only once after power-up and then held.
// - Pins may change afterwards without affecting the stored identifier.
// - Network option bit 3 takes the identifier directly from the axis register.
module node_id_pin_mapper #(
    parameter int NUM_PINS = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [NUM_PINS-1:0] i_pins,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [node_id_pkg::ID_W-1:0] o_node_id,
    output logic o_id_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic [NUM_PINS-1:0] pins_meta;
    logic [NUM_PINS-1:0] pins_sync;

    always_ff @(posedge i_core_clk) begin
        pins_meta <= i_pins;
        pins_sync <= pins_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [31:0] pin_map;
    logic [node_id_pkg::COUNT_W-1:0] pin_count;
    logic net_opt_axis;
    logic [31:0] axis_ids;
    logic go_pending;
    logic capture;
    node_id_pkg::boot_state_t state;
    logic [1:0] settle_cnt;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pin_map <= node_id_pkg::PIN_MAP_RESET;
            pin_count <= node_id_pkg::PIN_COUNT_RESET;
            net_opt_axis <= 1'h0;
            axis_ids <= node_id_pkg::AXIS_IDS_RESET;
        end else if (i_wr) begin
            case (i_addr)
                node_id_pkg::OFF_PIN_MAP: begin
                    // Reserved bits 28-30 are not stored
                    pin_map <= i_wdata & node_id_pkg::PIN_MAP_MASK;
                end
                node_id_pkg::OFF_PIN_COUNT: begin
                    pin_count <= i_wdata[node_id_pkg::COUNT_W-1:0];
                end
                node_id_pkg::OFF_NET_OPT: begin
                    net_opt_axis <= i_wdata[node_id_pkg::NET_OPT_AXIS_BIT];
                end
                node_id_pkg::OFF_AXIS_IDS: begin
                    axis_ids <= i_wdata & node_id_pkg::AXIS_IDS_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Start request; remembered if it comes while pins still settle
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            go_pending <= 1'h0;
        end else if (i_wr && i_addr == node_id_pkg::OFF_CTRL
                     && i_wdata[node_id_pkg::CTRL_GO_BIT]) begin
            go_pending <= 1'h1;
        end else if (capture) begin
            go_pending <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot sequencer: settle, wait for start, capture once
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= node_id_pkg::st_settle;
            settle_cnt <= 2'h0;
        end else begin
            case (state)
                node_id_pkg::st_settle: begin
                    settle_cnt <= settle_cnt + 2'h1;
                    if (settle_cnt == node_id_pkg::SETTLE_CYCLES - 2'h1) begin
                        state <= node_id_pkg::st_idle;
                    end
                end
                node_id_pkg::st_idle: begin
                    if (go_pending) begin
                        state <= node_id_pkg::st_done;
                    end
                end
                node_id_pkg::st_done: begin
                    state <= node_id_pkg::st_done;
                end
                default: begin
                    state <= node_id_pkg::st_settle;
                end
            endcase
        end
    end

    assign capture = (state == node_id_pkg::st_idle) && go_pending;

    ////////////////////////////////////////////////////////////////////////
    // Identifier bit selection
    logic [node_id_pkg::ID_W-1:0] mapped_id;

    for (genvar b = 0; b < node_id_pkg::ID_W; b++) begin : g_bit
        id_bit_select #(
            .NUM_PINS(NUM_PINS),
            .BIT_IDX(b)
        ) u_bit (
            .i_pins(pins_sync),
            .i_sel(pin_map[b*node_id_pkg::NIBBLE_W +: node_id_pkg::NIBBLE_W]),
            .i_custom(pin_map[node_id_pkg::MAP_EN_BIT]),
            .i_count(pin_count),
            .o_bit(mapped_id[b])
        );
    end

    // Captured once; later pin activity never reaches the result
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_node_id <= '0;
            o_id_valid <= 1'h0;
        end else if (capture) begin
            o_id_valid <= 1'h1;
            if (net_opt_axis) begin
                o_node_id <= axis_ids[node_id_pkg::ID_W-1:0];
            end else begin
                o_node_id <= mapped_id;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 32'h00000000;
        end else begin
            case (i_addr)
                node_id_pkg::OFF_PIN_MAP: o_rdata <= pin_map;
                node_id_pkg::OFF_PIN_COUNT: o_rdata <= {29'h0, pin_count};
                node_id_pkg::OFF_NET_OPT: begin
                    o_rdata <= {28'h0, net_opt_axis, 3'h0};
                end
                node_id_pkg::OFF_AXIS_IDS: o_rdata <= axis_ids;
                node_id_pkg::OFF_STATUS: begin
                    o_rdata <= {23'h0, o_id_valid, 1'h0, o_node_id};
                end
                default: o_rdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    logic custom_cap;
    logic default_cap;

    assign custom_cap = capture && !net_opt_axis && pin_map[node_id_pkg::MAP_EN_BIT];
    assign default_cap = capture && !net_opt_axis && !pin_map[node_id_pkg::MAP_EN_BIT];

    a_zero_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
        capture && !net_opt_axis && pin_count == 3'h0 |=> o_node_id == '0)
        else $error("zero pin count did not give zero identifier");

    a_custom_bit0: assert property (@(posedge i_core_clk) disable iff (i_rst)
        custom_cap && pin_count >= 3'h1 |=> o_node_id[0] == $past(pins_sync[pin_map[3:0]]))
        else $error("identifier bit 0 not from mapped pin");

    a_custom_bit6: assert property (@(posedge i_core_clk) disable iff (i_rst)
        custom_cap && pin_count == 3'h7
        |=> o_node_id[6] == $past(pins_sync[pin_map[27:24]]))
        else $error("identifier bit 6 not from mapped pin");

    a_custom_bit1: assert property (@(posedge i_core_clk) disable iff (i_rst)
        custom_cap && pin_count >= 3'h2 |=> o_node_id[1] == $past(pins_sync[pin_map[7:4]]))
        else $error("custom mapping not applied to bit 1");

    a_default_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        default_cap && pin_count >= 3'h1
        |=> o_node_id[0] == $past(pins_sync[NUM_PINS - int'(pin_count)]))
        else $error("default mapping did not ignore nibbles");

    a_default_top: assert property (@(posedge i_core_clk) disable iff (i_rst)
        default_cap && pin_count >= 3'h1
        |=> o_node_id[$past(pin_count) - 3'h1] == $past(pins_sync[NUM_PINS-1]))
        else $error("highest pin not on highest used bit");

    a_custom_bit3: assert property (@(posedge i_core_clk) disable iff (i_rst)
        custom_cap && pin_count >= 3'h4
        |=> o_node_id[3] == $past(pins_sync[pin_map[15:12]]))
        else $error("nibble 3 not used as pin index");

    a_single_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_id_valid |-> !capture ##1 o_id_valid)
        else $error("identifier captured more than once");

    a_id_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_id_valid ##1 o_id_valid |-> $stable(o_node_id))
        else $error("stored identifier changed after capture");

    a_axis_direct: assert property (@(posedge i_core_clk) disable iff (i_rst)
        capture && net_opt_axis |=> o_node_id == $past(axis_ids[6:0]))
        else $error("axis identifier not taken directly");

    a_upper_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        capture && !net_opt_axis |=> (o_node_id >> $past(pin_count)) == '0)
        else $error("bits above pin count not zero");

    c_custom: cover property (@(posedge i_core_clk) disable iff (i_rst)
        custom_cap && pin_count == 3'h3);
    c_default: cover property (@(posedge i_core_clk) disable iff (i_rst)
        default_cap && pin_count == 3'h3);
    c_axis: cover property (@(posedge i_core_clk) disable iff (i_rst)
        capture && net_opt_axis);

endmodule : node_id_pin_mapper

// ===== common/node_id_pkg.sv
// Constants, register map and types for the node identifier pin mapper.
// Assumes a 32-bit register port with byte offsets and one core clock.
package node_id_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_PIN_MAP = 8'h00;
    localparam logic [7:0] OFF_PIN_COUNT = 8'h04;
    localparam logic [7:0] OFF_NET_OPT = 8'h08;
    localparam logic [7:0] OFF_AXIS_IDS = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // Field layout
    localparam int ID_W = 7;
    localparam int NIBBLE_W = 4;
    localparam int COUNT_W = 3;
    localparam int MAP_EN_BIT = 31;
    localparam int NET_OPT_AXIS_BIT = 3;
    localparam int CTRL_GO_BIT = 0;
    localparam int STATUS_DONE_BIT = 8;
    localparam logic [31:0] PIN_MAP_MASK = 32'h8FFFFFFF;
    localparam logic [31:0] AXIS_IDS_MASK = 32'h7F7F7F7F;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] PIN_MAP_RESET = 32'h00000000;
    localparam logic [COUNT_W-1:0] PIN_COUNT_RESET = 3'h0;
    localparam logic [31:0] AXIS_IDS_RESET = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Timing: two synchroniser stages must fill before pins are trusted
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    typedef enum logic [1:0] {st_settle, st_idle, st_done} boot_state_t;

endpackage : node_id_pkg

// ===== rtl/id_bit_select.sv
// One identifier bit: picks its source pin by custom nibble or default order.
// Assumes pins are already synchronised to the core clock.
`timescale 1ns/10ps
module id_bit_select #(
    parameter int NUM_PINS = 16,
    parameter int BIT_IDX = 0
) (
    input wire logic [NUM_PINS-1:0] i_pins,
    input wire logic [node_id_pkg::NIBBLE_W-1:0] i_sel,
    input wire logic i_custom,
    input wire logic [node_id_pkg::COUNT_W-1:0] i_count,
    output logic o_bit
);

    always_comb begin
        int def_idx;
        def_idx = NUM_PINS - int'(i_count) + BIT_IDX;
        o_bit = 1'h0;
        if (BIT_IDX < int'(i_count)) begin
            if (i_custom) begin
                // Pin index 0..15; a pin not fitted reads as zero
                if (int'(i_sel) < NUM_PINS) begin
                    o_bit = i_pins[i_sel];
                end
            end else if (def_idx >= 0 && def_idx < NUM_PINS) begin
                o_bit = i_pins[def_idx];
            end
        end
    end

endmodule : id_bit_select

// ===== tb/strap_pins_model.sv
// Strap and switch model that drives the identifier input pins.
// Assumes the bench sets the strap pattern and says when pins are reused.
`timescale 1ns/10ps
module strap_pins_model (
    input wire logic i_core_clk,
    input wire logic [15:0] i_strap,
    input wire logic i_reuse,
    output logic [15:0] o_pins
);
    ////////////////////////////////////////////////////////////////////////
    // Reused pins toggle every cycle so a late sample sees the inverted straps on every other cycle
    always_ff @(posedge i_core_clk) begin
        if (i_reuse) begin
            o_pins <= ~o_pins;
        end else begin
            o_pins <= i_strap;
        end
    end
endmodule : strap_pins_model

// ===== tb/node_id_pin_mapper_tb.sv
// Self-checking bench for the node identifier pin mapper.
// Assumes the strap model on the pins and a one-cycle register port.
`timescale 1ns/10ps
module node_id_pin_mapper_tb;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic reuse = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h00000000;
    logic [15:0] strap = 16'h0000;
    logic [15:0] pins;
    logic [31:0] o_rdata;
    logic [6:0] o_node_id;
    logic o_id_valid;
    int errors = 0;
    int n_checks = 0;

    initial forever #20 i_core_clk = ~i_core_clk;

    strap_pins_model i_pins_model (.i_core_clk(i_core_clk), .i_strap(strap), .i_reuse(reuse),
        .o_pins(pins));
    node_id_pin_mapper #(.NUM_PINS(16)) i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_pins(pins), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_node_id(o_node_id), .o_id_valid(o_id_valid));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stand one cycle only, then drop to zero
    task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        check(what, o_rdata, exp);
        @(posedge i_core_clk);
        #1;
        check("rdata idle", o_rdata, 32'h00000000);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] exp_id(logic [31:0] map, logic [2:0] cnt, logic [31:0] opt,
        logic [31:0] axis, logic [15:0] s);
        logic [6:0] id;
        int src;
        id = 7'h00;
        if (opt[3]) begin
            return axis[6:0];
        end
        for (int b = 0; b < 7; b++) begin
            src = map[31] ? int'(map[4*b +: 4]) : 16 - int'(cnt) + b;
            if (b < int'(cnt)) begin
                id[b] = s[src];
            end
        end
        return id;
    endfunction : exp_id

    // One power-up: reset, configure, capture, then disturb pins and config
    task automatic run(logic [31:0] map, logic [2:0] cnt, logic [31:0] opt, logic [31:0] axis,
        logic [15:0] s);
        logic [6:0] e;
        int k;
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        reuse <= 1'b0;
        strap <= s;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        e = exp_id(map, cnt, opt, axis, s);
        wr(node_id_pkg::OFF_PIN_MAP, map);
        wr(node_id_pkg::OFF_PIN_COUNT, {29'h0, cnt});
        wr(node_id_pkg::OFF_NET_OPT, opt);
        wr(node_id_pkg::OFF_AXIS_IDS, axis);
        rd(node_id_pkg::OFF_PIN_MAP, map & 32'h8FFFFFFF, "map");
        rd(node_id_pkg::OFF_PIN_COUNT, {29'h0, cnt}, "count");
        rd(node_id_pkg::OFF_NET_OPT, opt & 32'h00000008, "net opt");
        rd(node_id_pkg::OFF_AXIS_IDS, axis & 32'h7F7F7F7F, "axis ids");
        rd(node_id_pkg::OFF_STATUS, 32'h00000000, "status before");
        wr(node_id_pkg::OFF_CTRL, 32'h00000001);
        #1;
        k = 0;
        while (o_id_valid !== 1'b1 && k < 20) begin
            @(posedge i_core_clk);
            #1;
            k++;
        end
        // Judge by the flag, so a capture on the last try is not a timeout
        if (o_id_valid !== 1'b1) begin
            errors++;
            end_of_test();
        end
        check("id", 32'(o_node_id), 32'(e));
        reuse <= 1'b1;
        wr(node_id_pkg::OFF_PIN_MAP, ~map);
        wr(node_id_pkg::OFF_CTRL, 32'h00000001);
        repeat (4) @(posedge i_core_clk);
        #1;
        check("held id", {25'h0, o_node_id}, {25'h0, e});
        rd(node_id_pkg::OFF_STATUS, {23'h0, 1'b1, 1'b0, e}, "status after");
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(13));
        run(32'h80000012, 3'h3, 32'h0, 32'h0, 16'h0005);
        run(32'h7FFFFFFF, 3'h3, 32'h0, 32'h0, 16'hA000);
        run(32'h80000012, 3'h0, 32'h0, 32'h0, 16'hFFFF);
        run(32'hF6543210, 3'h7, 32'h0, 32'h0, 16'h5A3C);
        run(32'h80FEDCBA, 3'h2, 32'h0, 32'h0, 16'hFC00);
        run(32'h80000012, 3'h3, 32'h8, 32'h7F7F7F55, 16'h0007);
        run(32'h00000000, 3'h7, 32'h0, 32'h0, 16'h8100);
        for (int i = 0; i < 8; i++) begin
            run($urandom, 3'($urandom), $urandom & 32'h8, $urandom, 16'($urandom));
        end
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'h00000000, "unmapped");
        end_of_test();
    end
endmodule : node_id_pin_mapper_tb
